/* core/rdap_pkg.sv */
// Purpose: Shared constants and types for the read-with-auto-precharge link model
// Assumes: One clock (core_clk, 40 MHz); command and data sampled on its rising edge
// Notes  : Times in ns with cycle counts derived from the clock period
// Summary of operation
// - READ with A10 high means auto precharge
// - Precharge starts AL plus BL/2 after command
// - Delay precharge until tRAS and tRTP met
// - tRP counts from actual internal precharge start
// - BL4: activate after AL plus tRTP+tRP clocks
// - BL8: activate after AL+2 plus tRTP+tRP clocks
// - Round (tRTP+tRP)/tCK up to whole clocks
// - Precharge never before two clocks after prefetch
// - Other banks keep working during auto precharge
// - Other-bank spacing: BL/2 read, +2 write, 1
// - Explicit precharge only after tRAS elapsed
// - x16: each strobe times its own byte
// - x4/x8: single strobe times all lanes
// - Burst data follows programmed burst order; code always uses sequential order
// - No same-bank command until tRP elapsed
// - First data RL = AL + CL after READ
package rdap_pkg;
   localparam int CLK_PERIOD_PS = 25000;
   localparam int T_RAS_NS      = 40;
   localparam int T_RTP_NS      = 8;
   localparam int T_RP_NS       = 15;
   localparam int RAS_CYC  = (T_RAS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RTP_CYC  = (T_RTP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RP_CYC   = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RTPRP_CYC =
      ((T_RTP_NS + T_RP_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PF_GAP_CYC = 2;
   localparam int BL8_EXTRA  = 2;
   localparam int NUM_BANKS  = 8;
   localparam int BANK_W     = 3;
   localparam int COL_W      = 10;
   localparam int CNT_W      = 6;
   localparam int AP_BIT     = 10;
   localparam int DQ_W       = 16;
   localparam logic [2:0] AL_RESET = 3'h0;
   localparam logic [2:0] CL_RESET = 3'h3;
   typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE} cmd_t;
endpackage

/* core/rdap_if.sv */
`timescale 1ns/1ps
// Purpose: Command and read-data link between controller and memory end
// Assumes: Same clock at both ends
// Notes  : Strobes are modelled as per-byte valid flags
interface rdap_if;
   rdap_pkg::cmd_t              cmd;
   logic [rdap_pkg::BANK_W-1:0] bank;
   logic [13:0]                 addr;
   logic                        burst8;
   logic                        wide16;
   logic [rdap_pkg::DQ_W-1:0]   dq;
   logic                        dqs_lo;
   logic                        dqs_hi;
   logic [rdap_pkg::BANK_W-1:0] dq_bank;
   logic                        dq_ready;
   modport ctrl (output cmd, bank, addr, burst8, wide16, dq_ready,
                 input dq, dqs_lo, dqs_hi, dq_bank);
   modport mem  (input cmd, bank, addr, burst8, wide16, dq_ready,
                 output dq, dqs_lo, dqs_hi, dq_bank);
endinterface

/* core/rdap_mem.sv */
`timescale 1ns/1ps
// Purpose: Memory end: auto-precharge timing per bank and read data return
// Assumes: Controller keeps its spacing rules; AL, CL small
// Notes  : Two-entry buffer absorbs controller stalls on read data
module rdap_mem #(
   parameter logic [2:0] AL = rdap_pkg::AL_RESET,  // Additive latency
   parameter logic [2:0] CL = rdap_pkg::CL_RESET   // CAS latency
) (
   input  wire logic core_clk,                      // Clock
   input  wire logic reset,                         // Async reset, high
   rdap_if.mem       lnk,                           // Link
   output logic [rdap_pkg::NUM_BANKS-1:0] bank_open,   // Row open per bank
   output logic [rdap_pkg::NUM_BANKS-1:0] bank_pre     // Precharging per bank
);
   localparam int RL = int'(AL) + int'(CL);
   localparam int LW = 16;
   typedef logic [rdap_pkg::CNT_W-1:0] cnt_t;

   ////////////////////////////////////////////////////////////////////////
   // Per-bank state
   cnt_t ras [rdap_pkg::NUM_BANKS];
   cnt_t rtp [rdap_pkg::NUM_BANKS];
   cnt_t nom [rdap_pkg::NUM_BANKS];
   cnt_t rp  [rdap_pkg::NUM_BANKS];
   logic [rdap_pkg::NUM_BANKS-1:0] ap_pend;
   cnt_t next_ras [rdap_pkg::NUM_BANKS];
   cnt_t next_rtp [rdap_pkg::NUM_BANKS];
   cnt_t next_nom [rdap_pkg::NUM_BANKS];
   cnt_t next_rp  [rdap_pkg::NUM_BANKS];
   logic [rdap_pkg::NUM_BANKS-1:0] next_ap_pend, next_open, next_pre;

   always_comb begin
      for (int b = 0; b < rdap_pkg::NUM_BANKS; b++) begin
         logic hit;
         logic start;
         hit = (lnk.bank == b[rdap_pkg::BANK_W-1:0]);
         // Start only when nominal edge reached and tRAS, tRTP both met
         start = ap_pend[b] && nom[b] == '0 && ras[b] == '0 && rtp[b] == '0;
         next_ras[b] = (ras[b] != '0) ? ras[b] - cnt_t'(1) : ras[b];
         next_rtp[b] = (rtp[b] != '0) ? rtp[b] - cnt_t'(1) : rtp[b];
         next_nom[b] = (nom[b] != '0) ? nom[b] - cnt_t'(1) : nom[b];
         next_rp[b]  = (rp[b]  != '0) ? rp[b]  - cnt_t'(1) : rp[b];
         next_ap_pend[b] = ap_pend[b];
         next_open[b] = bank_open[b];
         next_pre[b]  = (rp[b] > cnt_t'(1));
         if (start) begin
            next_ap_pend[b] = 1'b0;
            next_open[b] = 1'b0;
            next_pre[b] = 1'b1;
            next_rp[b] = cnt_t'(rdap_pkg::RP_CYC);
         end
         if (hit) begin
            case (lnk.cmd)
               rdap_pkg::CMD_ACT: begin
                  next_open[b] = 1'b1;
                  next_ras[b] = cnt_t'(rdap_pkg::RAS_CYC - 1);
               end
               rdap_pkg::CMD_READ: begin
                  // Prefetch edge is AL (BL4) or AL+2 (BL8); tRTP and 2-clock gap from it
                  next_rtp[b] = cnt_t'(int'(AL) + (lnk.burst8 ? rdap_pkg::BL8_EXTRA : 0)
                     + ((rdap_pkg::RTP_CYC > rdap_pkg::PF_GAP_CYC) ?
                        rdap_pkg::RTP_CYC : rdap_pkg::PF_GAP_CYC) - 1);
                  if (lnk.addr[rdap_pkg::AP_BIT]) begin
                     next_ap_pend[b] = 1'b1;
                     next_nom[b] = cnt_t'(int'(AL) + (lnk.burst8 ? 4 : 2) - 1);
                  end
               end
               rdap_pkg::CMD_PRE: begin
                  next_open[b] = 1'b0;
                  next_pre[b] = 1'b1;
                  next_rp[b] = cnt_t'(rdap_pkg::RP_CYC);
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int b = 0; b < rdap_pkg::NUM_BANKS; b++) begin
            ras[b] <= '0;
            rtp[b] <= '0;
            nom[b] <= '0;
            rp[b]  <= '0;
         end
         ap_pend   <= '0;
         bank_open <= '0;
         bank_pre  <= '0;
      end else begin
         ras <= next_ras;
         rtp <= next_rtp;
         nom <= next_nom;
         rp  <= next_rp;
         ap_pend   <= next_ap_pend;
         bank_open <= next_open;
         bank_pre  <= next_pre;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read latency line: one slot per beat pair, a read spawns BL/2 slots
   logic [LW-1:0] lat_v, next_lat_v;
   logic [LW-1:0][rdap_pkg::COL_W-1:0] lat_col, next_lat_col;
   logic [LW-1:0][rdap_pkg::BANK_W-1:0] lat_bk, next_lat_bk;

   always_comb begin
      next_lat_v = {1'b0, lat_v[LW-1:1]};
      next_lat_col = {{rdap_pkg::COL_W{1'b0}}, lat_col[LW-1:1]};
      next_lat_bk = {{rdap_pkg::BANK_W{1'b0}}, lat_bk[LW-1:1]};
      if (lnk.cmd == rdap_pkg::CMD_READ) begin
         for (int k = 0; k < 4; k++) begin
            if (k < 2 || lnk.burst8) begin
               // Sequential order within the burst, wrapping in 4 or 8
               next_lat_v[RL - 1 + k] = 1'b1;
               next_lat_col[RL - 1 + k] = lnk.burst8 ?
                  {lnk.addr[rdap_pkg::COL_W-1:3], 3'(lnk.addr[2:0] + 3'(2 * k))} :
                  {lnk.addr[rdap_pkg::COL_W-1:2], 2'(lnk.addr[1:0] + 2'(2 * k))};
               next_lat_bk[RL - 1 + k] = lnk.bank;
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         lat_v <= '0;
         lat_col <= '0;
         lat_bk <= '0;
      end else begin
         lat_v <= next_lat_v;
         lat_col <= next_lat_col;
         lat_bk <= next_lat_bk;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Two-entry output buffer; data word is bank and column pattern
   logic [1:0][rdap_pkg::DQ_W+rdap_pkg::BANK_W-1:0] buf_d, next_buf_d;
   logic [1:0] cnt, next_cnt;
   logic [rdap_pkg::DQ_W-1:0] beat;
   logic [rdap_pkg::DQ_W-1:0] next_dq;
   logic next_lo, next_hi;
   logic [rdap_pkg::BANK_W-1:0] next_dbk;
   logic pop;

   always_comb begin
      beat = {lat_bk[0], 3'h0, lat_col[0]};
      pop = lnk.dqs_lo && lnk.dq_ready;
      next_buf_d = buf_d;
      next_cnt = cnt;
      if (pop) begin
         next_buf_d[0] = buf_d[1];
         next_cnt = cnt - 2'h1;
      end
      if (lat_v[0] && next_cnt != 2'h2) begin
         next_buf_d[next_cnt[0]] = {lat_bk[0], beat};
         next_cnt = next_cnt + 2'h1;
      end
      next_lo = (next_cnt != 2'h0);
      // x16 has upper strobe for upper byte; x4/x8 use only the lower strobe
      next_hi = next_lo && lnk.wide16;
      next_dq = next_lo ? next_buf_d[0][rdap_pkg::DQ_W-1:0] : '0;
      if (!lnk.wide16) next_dq[15:8] = 8'h00;
      next_dbk = next_buf_d[0][rdap_pkg::DQ_W+rdap_pkg::BANK_W-1:rdap_pkg::DQ_W];
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         buf_d <= '0;
         cnt <= 2'h0;
         lnk.dq <= '0;
         lnk.dqs_lo <= 1'b0;
         lnk.dqs_hi <= 1'b0;
         lnk.dq_bank <= '0;
      end else begin
         buf_d <= next_buf_d;
         cnt <= next_cnt;
         lnk.dq <= next_dq;
         lnk.dqs_lo <= next_lo;
         lnk.dqs_hi <= next_hi;
         lnk.dq_bank <= next_dbk;
      end
   end
endmodule

/* core/rdap_ctrl.sv */
`timescale 1ns/1ps
// Purpose: Controller end: issues commands only when bank spacing allows
// Assumes: User request held until accepted
// Notes  : Per-bank counters enforce activate and precharge spacing
module rdap_ctrl (
   input  wire logic core_clk,                          // Clock
   input  wire logic reset,                             // Async reset, high
   rdap_if.ctrl      lnk,                               // Link
   input  wire rdap_pkg::cmd_t req_cmd,                 // Requested command
   input  wire logic [rdap_pkg::BANK_W-1:0] req_bank,   // Requested bank
   input  wire logic [13:0] req_addr,                   // Address, bit 10 = auto precharge
   input  wire logic req_valid,                         // Request present
   input  wire logic burst8,                            // Burst length eight
   input  wire logic wide16,                            // x16 part
   input  wire logic rd_ready,                          // User takes data
   output logic req_taken,                              // Request issued
   output logic [rdap_pkg::DQ_W-1:0] rd_data,           // Read data
   output logic rd_valid                                // Read data valid
);
   typedef logic [rdap_pkg::CNT_W-1:0] cnt_t;
   localparam logic [2:0] AL = rdap_pkg::AL_RESET;
   cnt_t busy [rdap_pkg::NUM_BANKS];
   cnt_t next_busy [rdap_pkg::NUM_BANKS];
   cnt_t ras [rdap_pkg::NUM_BANKS];
   cnt_t next_ras [rdap_pkg::NUM_BANKS];
   cnt_t gap_rd, gap_wr, gap_any, next_gap_rd, next_gap_wr, next_gap_any;
   logic ok;
   rdap_pkg::cmd_t next_cmd;

   always_comb begin
      ok = 1'b0;
      for (int b = 0; b < rdap_pkg::NUM_BANKS; b++) begin
         next_busy[b] = (busy[b] != '0) ? busy[b] - cnt_t'(1) : busy[b];
         next_ras[b]  = (ras[b] != '0) ? ras[b] - cnt_t'(1) : ras[b];
      end
      next_gap_rd  = (gap_rd != '0) ? gap_rd - cnt_t'(1) : gap_rd;
      next_gap_wr  = (gap_wr != '0) ? gap_wr - cnt_t'(1) : gap_wr;
      next_gap_any = (gap_any != '0) ? gap_any - cnt_t'(1) : gap_any;
      if (req_valid && busy[req_bank] == '0) begin
         case (req_cmd)
            rdap_pkg::CMD_READ:  ok = (gap_rd == '0);
            rdap_pkg::CMD_WRITE: ok = (gap_wr == '0);
            rdap_pkg::CMD_PRE:   ok = (gap_any == '0) && ras[req_bank] == '0;
            rdap_pkg::CMD_ACT:   ok = (gap_any == '0);
            default:             ok = 1'b1;
         endcase
      end
      next_cmd = ok ? req_cmd : rdap_pkg::CMD_NOP;
      if (ok) begin
         case (req_cmd)
            rdap_pkg::CMD_ACT: next_ras[req_bank] = cnt_t'(rdap_pkg::RAS_CYC - 1);
            rdap_pkg::CMD_PRE: next_busy[req_bank] = cnt_t'(rdap_pkg::RP_CYC - 1);
            rdap_pkg::CMD_READ: begin
               if (req_addr[rdap_pkg::AP_BIT]) begin
                  // Activate spacing: AL (+2 for BL8) + ceil((tRTP+tRP)/tCK), plus any tRAS
                  // left; the prefetch gap is added as precharge never starts sooner
                  next_busy[req_bank] = cnt_t'(int'(AL) + (burst8 ? rdap_pkg::BL8_EXTRA : 0)
                     + rdap_pkg::PF_GAP_CYC + rdap_pkg::RTPRP_CYC - 1
                     + int'(ras[req_bank]));
                  next_gap_rd  = cnt_t'((burst8 ? 4 : 2) - 1);
                  next_gap_wr  = cnt_t'((burst8 ? 4 : 2) + 2 - 1);
                  next_gap_any = cnt_t'(0);
               end else begin
                  next_gap_rd = cnt_t'((burst8 ? 4 : 2) - 1);
                  next_gap_wr = cnt_t'((burst8 ? 4 : 2) + 2 - 1);
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int b = 0; b < rdap_pkg::NUM_BANKS; b++) begin
            busy[b] <= '0;
            ras[b] <= '0;
         end
         gap_rd <= '0;
         gap_wr <= '0;
         gap_any <= '0;
         req_taken <= 1'b0;
         lnk.cmd <= rdap_pkg::CMD_NOP;
         lnk.bank <= '0;
         lnk.addr <= '0;
         lnk.burst8 <= 1'b0;
         lnk.wide16 <= 1'b0;
         lnk.dq_ready <= 1'b0;
         rd_data <= '0;
         rd_valid <= 1'b0;
      end else begin
         busy <= next_busy;
         ras <= next_ras;
         gap_rd <= next_gap_rd;
         gap_wr <= next_gap_wr;
         gap_any <= next_gap_any;
         req_taken <= ok;
         lnk.cmd <= next_cmd;
         lnk.bank <= req_bank;
         lnk.addr <= req_addr;
         lnk.burst8 <= burst8;
         lnk.wide16 <= wide16;
         lnk.dq_ready <= rd_ready;
         rd_valid <= lnk.dqs_lo && lnk.dq_ready;
         rd_data <= lnk.dq;
      end
   end
endmodule

/* test/rdap_chk.sv */
`timescale 1ns/1ps
// Purpose: Link checker between the controller end and the memory end
// Assumes: AL and CL at their package reset values
// Notes  : Sees the interface signals only
module rdap_chk (
   input wire logic                        core_clk,  // Clock
   input wire logic                        reset,     // Async reset, high
   input wire rdap_pkg::cmd_t              cmd,       // Command
   input wire logic [rdap_pkg::BANK_W-1:0] bank,      // Command bank
   input wire logic [13:0]                 addr,      // Address
   input wire logic                        burst8,    // Burst length eight
   input wire logic                        wide16,    // x16 part
   input wire logic [rdap_pkg::DQ_W-1:0]   dq,        // Read word
   input wire logic                        dqs_lo,    // Low strobe
   input wire logic                        dqs_hi,    // High strobe
   input wire logic [rdap_pkg::BANK_W-1:0] dq_bank,   // Bank of word
   input wire logic                        dq_ready   // Word taken
);
   localparam int RD_FIRST = 4;
   localparam int RD_LAST  = 5;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_rdap;
      cmd == rdap_pkg::CMD_READ && addr[rdap_pkg::AP_BIT];
   endsequence
   sequence s_rd_open;
      cmd == rdap_pkg::CMD_READ && dq_ready;
   endsequence
   a_read_data_latency: assert property (
      s_rd_open |-> ##[RD_FIRST:RD_LAST] dqs_lo)
      else $error("read word not presented in time");
   a_bl4_read_gap: assert property (
      (s_rdap ##0 !burst8) |=> cmd != rdap_pkg::CMD_READ)
      else $error("read too soon after auto precharge read");
   a_bl8_read_gap: assert property (
      (s_rdap ##0 burst8) |=> (cmd != rdap_pkg::CMD_READ)[*3])
      else $error("read too soon after auto precharge read");
   a_bl4_write_gap: assert property (
      (s_rdap ##0 !burst8) |=> (cmd != rdap_pkg::CMD_WRITE)[*3])
      else $error("write too soon after auto precharge read");
   a_bl8_write_gap: assert property (
      (s_rdap ##0 burst8) |=> (cmd != rdap_pkg::CMD_WRITE)[*5])
      else $error("write too soon after auto precharge read");
   a_act_after_ap: assert property (
      cmd == rdap_pkg::CMD_ACT |->
         !($past(cmd, 2) == rdap_pkg::CMD_READ && $past(addr[rdap_pkg::AP_BIT], 2)
           && $past(bank, 2) == bank)
         && !($past(cmd) == rdap_pkg::CMD_READ && $past(addr[rdap_pkg::AP_BIT])
           && $past(bank) == bank))
      else $error("activate before auto precharge done");
   a_pre_after_act: assert property (
      cmd == rdap_pkg::CMD_PRE |-> !($past(cmd) == rdap_pkg::CMD_ACT && $past(bank) == bank))
      else $error("precharge before row active time");
   a_strobe_lanes: assert property (
      dqs_lo |-> dqs_hi == wide16)
      else $error("upper strobe does not match part width");
   a_hi_needs_lo: assert property (
      dqs_hi |-> dqs_lo)
      else $error("upper strobe without lower strobe");
   a_word_bank: assert property (
      dqs_lo |-> (wide16 ? dq[15:13] == dq_bank : dq[15:8] == 8'h00))
      else $error("word bank field mismatch");
endmodule

/* test/ddr2_read_auto_precharge_test.sv */
`timescale 1ns/1ps
// Purpose: Self-checking bench joining controller end and memory end
// Assumes: AL 0, CL 3; user stalls last one cycle, at least twelve apart
// Notes  : Expected words and precharge cycles are queued by the driver
module ddr2_read_auto_precharge_test;
   logic                           core_clk;
   logic                           reset;
   rdap_pkg::cmd_t                 req_cmd;
   logic [2:0]                     req_bank;
   logic [13:0]                    req_addr;
   logic                           req_valid;
   logic                           burst8;
   logic                           wide16;
   logic                           rd_ready;
   logic                           req_taken;
   logic [15:0]                    rd_data;
   logic                           rd_valid;
   logic [7:0]                     bank_open;
   logic [7:0]                     bank_pre;
   logic [7:0]                     pre_prev;
   logic [15:0]                    word_q[$];
   int                             cyc_q[$];
   int                             errors;
   int                             comparisons;
   int                             cycles;
   int                             seed;
   int                             quiet;
   logic [2:0]                     b1;
   logic [9:0]                     col;
   rdap_if i_rdap_if ();
   rdap_mem i_rdap_mem (.core_clk(core_clk), .reset(reset), .lnk(i_rdap_if.mem),
                        .bank_open(bank_open), .bank_pre(bank_pre));
   rdap_ctrl i_rdap_ctrl (.core_clk(core_clk), .reset(reset), .lnk(i_rdap_if.ctrl),
      .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_valid(req_valid),
      .burst8(burst8), .wide16(wide16), .rd_ready(rd_ready), .req_taken(req_taken),
      .rd_data(rd_data), .rd_valid(rd_valid));
   rdap_chk i_rdap_chk (.core_clk(core_clk), .reset(reset), .cmd(i_rdap_if.cmd),
      .bank(i_rdap_if.bank), .addr(i_rdap_if.addr), .burst8(i_rdap_if.burst8),
      .wide16(i_rdap_if.wide16), .dq(i_rdap_if.dq), .dqs_lo(i_rdap_if.dqs_lo),
      .dqs_hi(i_rdap_if.dqs_hi), .dq_bank(i_rdap_if.dq_bank), .dq_ready(i_rdap_if.dq_ready));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic results;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_cycle(input int got, input int exp);
      comparisons++;
      if (got != exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Holds the request until taken, then notes what must follow
   task automatic issue(input rdap_pkg::cmd_t c, input logic [2:0] b, input logic [13:0] a);
      int         n;
      logic [9:0] m;
      n = 0;
      m = burst8 ? 10'h007 : 10'h003;
      req_cmd = c;
      req_bank = b;
      req_addr = a;
      req_valid = 1'b1;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (req_taken !== 1'b1 && n < 100);
      req_valid = 1'b0;
      if (n == 100)
         errors++;
      if (c == rdap_pkg::CMD_READ) begin
         // Narrow parts carry no upper byte
         for (int k = 0; k < (burst8 ? 4 : 2); k++)
            word_q.push_back({b, 3'h0, (a[9:0] & ~m) | ((a[9:0] + 10'(2 * k)) & m)}
               & (wide16 ? 16'hffff : 16'h00ff));
         if (a[rdap_pkg::AP_BIT])
            cyc_q.push_back(cycles + 1 + int'(rdap_pkg::AL_RESET) + (burst8 ? 4 : 2));
      end
      // Let an edge pass so the next call never re-raises valid in this step
      @(posedge core_clk);
      #1;
   endtask
   task automatic drain;
      int n;
      n = 0;
      while ((word_q.size() > 0 || cyc_q.size() > 0) && n < 200) begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      #1;
      // Single stalls, spaced so one burst pair never overruns the two-word buffer
      rd_ready = (quiet < 12) || (($random(seed) & 3) != 0);
      quiet = rd_ready ? quiet + 1 : 0;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      pre_prev <= bank_pre;
      // Every valid word was already taken from the link
      if (rd_valid === 1'b1 && word_q.size() == 0)
         check_word(rd_data, 16'hxxxx);
      else if (rd_valid === 1'b1)
         check_word(rd_data, word_q.pop_front());
      for (int i = 0; i < 8; i++)
         if (bank_pre[i] === 1'b1 && pre_prev[i] !== 1'b1 && cyc_q.size() > 0)
            check_cycle(cycles, cyc_q.pop_front());
      if (cycles >= 5000) begin
         errors++;
         results();
      end
   end
   initial begin
      seed = 32'hb35a5cbe;
      {errors, comparisons} = '0;
      {req_bank, req_addr, req_valid, burst8, wide16} = '0;
      req_cmd = rdap_pkg::CMD_NOP;
      reset = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      reset = 1'b0;
      issue(rdap_pkg::CMD_ACT, 3'h5, 14'h0000);
      issue(rdap_pkg::CMD_PRE, 3'h5, 14'h0000);
      $display("test precharge after activate done");
      for (int t = 0; t < 16; t++) begin
         burst8 = t[0];
         wide16 = t[1];
         b1 = 3'($random(seed));
         col = 10'($random(seed)) & 10'h3fe;
         issue(rdap_pkg::CMD_ACT, b1, 14'h0000);
         issue(rdap_pkg::CMD_ACT, b1 + 3'h1, 14'h0000);
         issue(rdap_pkg::CMD_ACT, b1 + 3'h2, 14'h0000);
         issue(rdap_pkg::CMD_READ, b1, {4'h1, col});
         issue(rdap_pkg::CMD_READ, b1 + 3'h1, {4'h1, ~col & 10'h3fe});
         issue(rdap_pkg::CMD_WRITE, b1 + 3'h2, 14'h0000);
         issue(rdap_pkg::CMD_ACT, b1, 14'h0000);
         drain();
         issue(rdap_pkg::CMD_PRE, b1, 14'h0000);
         issue(rdap_pkg::CMD_PRE, b1 + 3'h2, 14'h0000);
         $display("test burst %0d done", t);
      end
      drain();
      check_cycle(word_q.size() + cyc_q.size(), 0);
      results();
   end
endmodule
